// ==== shared/timer8_pkg.sv ====
// constants shared by the 8-bit compare waveform timer
// assumes a 32-bit AXI4-Lite master and a single 250 MHz clock
package timer8_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] control_off = 8'h00;
   localparam logic [7:0] count_off = 8'h04;
   localparam logic [7:0] compare_a_off = 8'h08;
   localparam logic [7:0] compare_b_off = 8'h0C;
   localparam logic [7:0] flags_off = 8'h10;
   localparam logic [7:0] force_off = 8'h14;
   localparam logic [7:0] port_off = 8'h18;
   localparam logic [7:0] status_off = 8'h1C;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int sel_a_lsb = 6;
   localparam int sel_b_lsb = 4;
   localparam int mode_lsb = 0;
   localparam int mode_msb_bit = 2;
   localparam int ovf_bit = 0;
   localparam int flag_a_bit = 1;
   localparam int flag_b_bit = 2;
   localparam int force_a_bit = 0;
   localparam int force_b_bit = 1;
   localparam int port_a_bit = 0;
   localparam int dir_a_bit = 1;
   localparam int port_b_bit = 2;
   localparam int dir_b_bit = 3;

   // ************************************************************
   // codes and values
   // ************************************************************
   localparam logic [2:0] mode_normal = 3'h0;
   localparam logic [2:0] mode_clear_on_match = 3'h2;
   localparam logic [2:0] mode_fast_max = 3'h3;
   localparam logic [2:0] mode_fast_cmp = 3'h7;
   localparam logic [1:0] sel_none = 2'h0;
   localparam logic [1:0] sel_toggle = 2'h1;
   localparam logic [1:0] sel_clear = 2'h2;
   localparam logic [1:0] sel_set = 2'h3;
   localparam logic [7:0] count_max = 8'hFF;
   localparam logic [7:0] count_bottom = 8'h00;
   localparam logic [7:0] byte_zero = 8'h00;
   localparam logic [1:0] resp_okay = 2'h0;
   localparam logic [1:0] resp_slverr = 2'h2;

endpackage

// ==== design/timer8_compare_waveform_gen.sv ====
// 8-bit timer with two compare output channels and an AXI4-Lite register port
// assumes timer_tick is a one-cycle enable from a prescaler on the same clock
//
// Overview of operation
// - reset clears both compare output states
// - nonzero selector routes state to pin value
// - direction bit alone enables pin driver
// - pin override ignores waveform mode
// - selector zero leaves state untouched
// - selector acts at next match; force acts now
// - only mode selector shapes counting
// - normal mode counts up, wraps 0xFF
// - normal mode overflow flag at zero
// - counter writable anytime in normal mode
// - clear-on-match mode clears at compare A
// - clear-on-match sets compare A flag at top
// - compare A unbuffered, late write wraps first
// - selector one toggles A every match
// - clear-on-match overflow flag on max wrap
// - fast PWM counts zero to top
// - fast PWM clears counter after top
// - fast PWM clear/set at match and bottom
// - fast PWM overflow flag at top
// - fast PWM toggle only A, mode msb set
// - compare zero spikes, maximum holds level
// - fast PWM compare values double buffered
// - buffered compare copied at top
// - compare flag after match, write one clears
// - counter write blocks next timer match
// - force updates state in non-PWM modes only, no flag, no clear
`timescale 1ns/100ps
`default_nettype none

module timer8_compare_waveform_gen
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic timer_tick,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic pin_out_a,
   output logic pin_oe_a,
   output logic pin_out_b,
   output logic pin_oe_b,
   output logic overflow_flag,
   output logic compare_flag_a,
   output logic compare_flag_b
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed
   {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [1:0] output_action_sel_a;
      logic [1:0] output_action_sel_b;
      logic [2:0] wave_mode_sel;
      logic [7:0] count_value;
      logic [7:0] compare_value_a;
      logic [7:0] compare_value_b;
      logic [7:0] compare_buf_a;
      logic [7:0] compare_buf_b;
      logic match_block;
      logic overflow_flag;
      logic compare_flag_a;
      logic compare_flag_b;
      logic compare_output_state_a;
      logic compare_output_state_b;
      logic [3:0] port_ctrl;
      logic pin_out_a;
      logic pin_oe_a;
      logic pin_out_b;
      logic pin_oe_b;
   } timer_state_s;

   timer_state_s cur;
   timer_state_s next_cur;

   // ************************************************************
   // output action helper
   // ************************************************************
   function automatic logic apply_action(input logic [1:0] sel, input logic state);
      logic result;
      result = state;
      if (sel == timer8_pkg::sel_toggle)
      begin
         result = ~state;
      end
      else if (sel == timer8_pkg::sel_clear)
      begin
         result = 1'b0;
      end
      else if (sel == timer8_pkg::sel_set)
      begin
         result = 1'b1;
      end
      return result;
   endfunction

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      logic fast_pwm;
      logic non_pwm;
      logic [7:0] top;
      logic at_top;
      logic match_a;
      logic match_b;
      logic wr_go;
      logic [7:0] wdat;
      logic wr_count;
      logic [1:0] force_hits;
      logic set_ovf;
      non_pwm = 1'b0;
      top = timer8_pkg::count_max;
      wr_go = 1'b0;
      wdat = s_axi_wdata[7:0];
      wr_count = 1'b0;
      force_hits = 2'b00;
      set_ovf = 1'b0;
      next_cur = cur;

      // counting shaped by mode only, never by selectors
      fast_pwm = (cur.wave_mode_sel == timer8_pkg::mode_fast_max) ||
                 (cur.wave_mode_sel == timer8_pkg::mode_fast_cmp);
      non_pwm = !fast_pwm;
      if (cur.wave_mode_sel == timer8_pkg::mode_fast_cmp)
      begin
         top = cur.compare_value_a;
      end
      at_top = (cur.count_value == top);
      match_a = timer_tick && !cur.match_block &&
                (cur.count_value == cur.compare_value_a);
      match_b = timer_tick && !cur.match_block &&
                (cur.count_value == cur.compare_value_b);

      // ********************************************************
      // counter and flags on the timer tick
      // ********************************************************
      if (timer_tick)
      begin
         next_cur.match_block = 1'b0;
         if (fast_pwm)
         begin
            if (at_top)
            begin
               next_cur.count_value = timer8_pkg::count_bottom;
               set_ovf = 1'b1;
               next_cur.compare_value_a = cur.compare_buf_a;
               next_cur.compare_value_b = cur.compare_buf_b;
            end
            else
            begin
               next_cur.count_value = cur.count_value + 8'h01;
            end
         end
         else if (cur.wave_mode_sel == timer8_pkg::mode_clear_on_match && match_a)
         begin
            // match only on equality, so a lowered compare A wraps first
            next_cur.count_value = timer8_pkg::count_bottom;
         end
         else
         begin
            next_cur.count_value = cur.count_value + 8'h01;
            set_ovf = (cur.count_value == timer8_pkg::count_max);
         end

         // waveform actions on real matches
         if (non_pwm)
         begin
            if (match_a)
            begin
               next_cur.compare_output_state_a =
                  apply_action(cur.output_action_sel_a, cur.compare_output_state_a);
            end
            if (match_b)
            begin
               next_cur.compare_output_state_b =
                  apply_action(cur.output_action_sel_b, cur.compare_output_state_b);
            end
         end
         else
         begin
            if (match_a && cur.output_action_sel_a == timer8_pkg::sel_toggle &&
                cur.wave_mode_sel[timer8_pkg::mode_msb_bit])
            begin
               next_cur.compare_output_state_a = ~cur.compare_output_state_a;
            end
            else if (match_a && cur.output_action_sel_a[1])
            begin
               next_cur.compare_output_state_a = cur.output_action_sel_a[0];
            end
            if (match_b && cur.output_action_sel_b[1])
            begin
               next_cur.compare_output_state_b = cur.output_action_sel_b[0];
            end
            // bottom after top wins, so maximum compare holds a level
            if (at_top && cur.output_action_sel_a[1])
            begin
               next_cur.compare_output_state_a = ~cur.output_action_sel_a[0];
            end
            if (at_top && cur.output_action_sel_b[1])
            begin
               next_cur.compare_output_state_b = ~cur.output_action_sel_b[0];
            end
         end
      end

      // ********************************************************
      // register write channel
      // ********************************************************
      if (!cur.awready && !cur.bvalid && s_axi_awvalid && s_axi_wvalid)
      begin
         next_cur.awready = 1'b1;
         next_cur.wready = 1'b1;
      end
      if (cur.awready)
      begin
         wr_go = s_axi_wstrb[0];
         next_cur.awready = 1'b0;
         next_cur.wready = 1'b0;
         next_cur.bvalid = 1'b1;
         next_cur.bresp = timer8_pkg::resp_okay;
         if (s_axi_awaddr > timer8_pkg::status_off || s_axi_awaddr[1:0] != 2'b00)
         begin
            next_cur.bresp = timer8_pkg::resp_slverr;
            wr_go = 1'b0;
         end
      end
      if (cur.bvalid && s_axi_bready)
      begin
         next_cur.bvalid = 1'b0;
      end

      if (wr_go)
      begin
         if (s_axi_awaddr == timer8_pkg::control_off)
         begin
            // new selector takes hold at the next match, not before
            next_cur.output_action_sel_a = wdat[timer8_pkg::sel_a_lsb +: 2];
            next_cur.output_action_sel_b = wdat[timer8_pkg::sel_b_lsb +: 2];
            next_cur.wave_mode_sel = wdat[timer8_pkg::mode_lsb +: 3];
         end
         else if (s_axi_awaddr == timer8_pkg::count_off)
         begin
            wr_count = 1'b1;
            next_cur.match_block = 1'b1;
         end
         else if (s_axi_awaddr == timer8_pkg::compare_a_off)
         begin
            next_cur.compare_buf_a = wdat;
            if (non_pwm)
            begin
               next_cur.compare_value_a = wdat;
            end
         end
         else if (s_axi_awaddr == timer8_pkg::compare_b_off)
         begin
            next_cur.compare_buf_b = wdat;
            if (non_pwm)
            begin
               next_cur.compare_value_b = wdat;
            end
         end
         else if (s_axi_awaddr == timer8_pkg::flags_off)
         begin
            // a flag set in this same cycle survives the clear
            if (wdat[timer8_pkg::ovf_bit])
            begin
               next_cur.overflow_flag = 1'b0;
            end
            if (wdat[timer8_pkg::flag_a_bit])
            begin
               next_cur.compare_flag_a = 1'b0;
            end
            if (wdat[timer8_pkg::flag_b_bit])
            begin
               next_cur.compare_flag_b = 1'b0;
            end
         end
         else if (s_axi_awaddr == timer8_pkg::force_off)
         begin
            force_hits[0] = wdat[timer8_pkg::force_a_bit] && non_pwm;
            force_hits[1] = wdat[timer8_pkg::force_b_bit] && non_pwm;
         end
         else if (s_axi_awaddr == timer8_pkg::port_off)
         begin
            next_cur.port_ctrl = wdat[3:0];
         end
      end

      // forced action: no flag, no counter clear
      if (force_hits[0])
      begin
         next_cur.compare_output_state_a =
            apply_action(cur.output_action_sel_a, cur.compare_output_state_a);
      end
      if (force_hits[1])
      begin
         next_cur.compare_output_state_b =
            apply_action(cur.output_action_sel_b, cur.compare_output_state_b);
      end

      // software counter write overrides count and clear
      if (wr_count)
      begin
         next_cur.count_value = wdat;
      end
      if (set_ovf)
      begin
         next_cur.overflow_flag = 1'b1;
      end
      if (match_a)
      begin
         next_cur.compare_flag_a = 1'b1;
      end
      if (match_b)
      begin
         next_cur.compare_flag_b = 1'b1;
      end

      // ********************************************************
      // register read channel
      // ********************************************************
      if (!cur.arready && !cur.rvalid && s_axi_arvalid)
      begin
         next_cur.arready = 1'b1;
      end
      if (cur.arready)
      begin
         next_cur.arready = 1'b0;
         next_cur.rvalid = 1'b1;
         next_cur.rresp = timer8_pkg::resp_okay;
         next_cur.rdata = 32'h0000_0000;
      end
      if (cur.arready)
      begin
         if (s_axi_araddr == timer8_pkg::control_off)
         begin
            next_cur.rdata[7:0] = {cur.output_action_sel_a, cur.output_action_sel_b,
                                   1'b0, cur.wave_mode_sel};
         end
         else if (s_axi_araddr == timer8_pkg::count_off)
         begin
            next_cur.rdata[7:0] = cur.count_value;
         end
         else if (s_axi_araddr == timer8_pkg::compare_a_off)
         begin
            next_cur.rdata[7:0] = cur.compare_buf_a;
         end
         else if (s_axi_araddr == timer8_pkg::compare_b_off)
         begin
            next_cur.rdata[7:0] = cur.compare_buf_b;
         end
         else if (s_axi_araddr == timer8_pkg::flags_off)
         begin
            next_cur.rdata[2:0] = {cur.compare_flag_b, cur.compare_flag_a,
                                   cur.overflow_flag};
         end
         else if (s_axi_araddr == timer8_pkg::force_off)
         begin
            next_cur.rdata[7:0] = timer8_pkg::byte_zero;
         end
         else if (s_axi_araddr == timer8_pkg::port_off)
         begin
            next_cur.rdata[3:0] = cur.port_ctrl;
         end
         else if (s_axi_araddr == timer8_pkg::status_off)
         begin
            next_cur.rdata[1:0] = {cur.compare_output_state_b, cur.compare_output_state_a};
         end
         else
         begin
            next_cur.rresp = timer8_pkg::resp_slverr;
         end
      end
      if (cur.rvalid && s_axi_rready)
      begin
         next_cur.rvalid = 1'b0;
      end

      // ********************************************************
      // pin override, independent of mode
      // ********************************************************
      next_cur.pin_out_a = (next_cur.output_action_sel_a != timer8_pkg::sel_none) ?
                           next_cur.compare_output_state_a :
                           next_cur.port_ctrl[timer8_pkg::port_a_bit];
      next_cur.pin_out_b = (next_cur.output_action_sel_b != timer8_pkg::sel_none) ?
                           next_cur.compare_output_state_b :
                           next_cur.port_ctrl[timer8_pkg::port_b_bit];
      next_cur.pin_oe_a = next_cur.port_ctrl[timer8_pkg::dir_a_bit];
      next_cur.pin_oe_b = next_cur.port_ctrl[timer8_pkg::dir_b_bit];
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         cur <= '0;
      end
      else
      begin
         cur <= next_cur;
      end
   end

   assign s_axi_awready = cur.awready;
   assign s_axi_wready = cur.wready;
   assign s_axi_bresp = cur.bresp;
   assign s_axi_bvalid = cur.bvalid;
   assign s_axi_arready = cur.arready;
   assign s_axi_rdata = cur.rdata;
   assign s_axi_rresp = cur.rresp;
   assign s_axi_rvalid = cur.rvalid;
   assign pin_out_a = cur.pin_out_a;
   assign pin_oe_a = cur.pin_oe_a;
   assign pin_out_b = cur.pin_out_b;
   assign pin_oe_b = cur.pin_oe_b;
   assign overflow_flag = cur.overflow_flag;
   assign compare_flag_a = cur.compare_flag_a;
   assign compare_flag_b = cur.compare_flag_b;

endmodule

`default_nettype wire

// ==== verification/pin_load.sv ====
// pad with a pull-up resistor, seen by the circuit on a compare pin
// assumes drive and enable come straight from the timer pin outputs
`timescale 1ns/100ps
`default_nettype none

module pin_load
(
   input wire logic drive,
   input wire logic enable,
   output logic level
);
   // released pad floats up
   assign level = enable ? drive : 1'b1;
endmodule

`default_nettype wire

// ==== verification/timer8_chk.sv ====
// concurrent checks on the timer's ports
// assumes a master holding payloads until ready
`timescale 1ns/100ps
`default_nettype none

module timer8_chk
(
   input wire logic clock,
   input wire logic rst_b,
   input wire logic timer_tick,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic pin_out_a,
   input wire logic pin_oe_a,
   input wire logic overflow_flag,
   input wire logic compare_flag_a,
   input wire logic compare_flag_b
);
   // ************************************************************
   // shadow of software writes
   // ************************************************************
   logic [7:0] port_sh;
   logic [7:0] ctl_sh;
   logic wr_go;
   logic clr_ovf;
   assign wr_go = s_axi_awready && s_axi_wstrb[0];
   assign clr_ovf = wr_go && s_axi_awaddr == timer8_pkg::flags_off && s_axi_wdata[0];
   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         port_sh <= 8'h00;
         ctl_sh <= 8'h00;
      end
      else if (wr_go && s_axi_awaddr == timer8_pkg::port_off)
         port_sh <= s_axi_wdata[7:0];
      else if (wr_go && s_axi_awaddr == timer8_pkg::control_off)
         ctl_sh <= s_axi_wdata[7:0];
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   sequence s_wr_ack;
      s_axi_awready && s_axi_wready ##1 s_axi_bvalid;
   endsequence
   sequence s_rd_ack;
      s_axi_arready ##1 s_axi_rvalid;
   endsequence
   a_reset_clear: assert property ($past(rst_b) == 1'b0 |-> !pin_out_a && !pin_oe_a)
      else $error("pins not clear");
   a_write_resp: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
      && !s_axi_bvalid |=> s_wr_ack)
      else $error("write answer late");
   a_read_resp: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid |=> s_rd_ack)
      else $error("read answer late");
   a_oe_dir: assert property (pin_oe_a == port_sh[timer8_pkg::dir_a_bit])
      else $error("enable not direction bit");
   a_out_port: assert property (ctl_sh[7:6] == 2'h0 |-> pin_out_a == port_sh[0])
      else $error("pin not port bit");
   a_pin_cause: assert property ($changed(pin_out_a) |-> $past(timer_tick)
      || $past(s_axi_awready))
      else $error("pin moved alone");
   a_ovf_tick: assert property ($rose(overflow_flag) |-> $past(timer_tick))
      else $error("overflow without tick");
   a_cmp_tick: assert property ($rose(compare_flag_a) || $rose(compare_flag_b)
      |-> $past(timer_tick))
      else $error("compare without tick");
   a_ovf_clear: assert property ($fell(overflow_flag) |-> $past(clr_ovf))
      else $error("overflow cleared alone");
endmodule

bind timer8_compare_waveform_gen timer8_chk i_timer8_chk (.clock, .rst_b, .timer_tick,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .pin_out_a, .pin_oe_a, .overflow_flag, .compare_flag_a,
   .compare_flag_b);

`default_nettype wire

// ==== verification/timer8_compare_waveform_gen_bench.sv ====
// self-checking bench for the compare waveform timer
// assumes AXI4-Lite answers within 99 cycles
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, want) begin total_checks++; if ((got) !== (want)) begin mismatches++; \
   $display("unexpected at %0t: got %h want %h", $time, got, want); end end

module timer8_compare_waveform_gen_bench;
   localparam logic [1:0] okay = timer8_pkg::resp_okay;
   localparam logic [1:0] sels [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic timer_tick = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00;
   logic [7:0] s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0;
   logic s_axi_wvalid = 1'b0;
   logic s_axi_arvalid = 1'b0;
   logic s_axi_bready = 1'b1;
   logic s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, bw;
   logic [31:0] s_axi_rdata;
   logic pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, pad_a, pad_b, st, pa;
   logic overflow_flag, compare_flag_a, compare_flag_b;
   int mismatches = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'h29;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [8:0] pq[$];
   logic [33:0] ew;
   logic [8:0] pw;
   logic [7:0] r;
   event look;

   timer8_compare_waveform_gen i_timer8_compare_waveform_gen (.clock(clock), .rst_b(rst_b),
      .timer_tick(timer_tick), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .pin_out_a(pin_out_a), .pin_oe_a(pin_oe_a), .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b),
      .overflow_flag(overflow_flag), .compare_flag_a(compare_flag_a),
      .compare_flag_b(compare_flag_b));
   pin_load i_pin_load_a (.drive(pin_out_a), .enable(pin_oe_a), .level(pad_a));
   pin_load i_pin_load_b (.drive(pin_out_b), .enable(pin_oe_b), .level(pad_b));

   // ************************************************************
   // helpers and bus tasks
   // ************************************************************
   initial
      forever #2 clock = ~clock;

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [33:0] okv(input logic [7:0] d);
      return {okay, 24'h0, d};
   endfunction

   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic guard(input int n);
      if (n >= 99)
      begin
         mismatches++;
         $display("unexpected at %0t: no answer", $time);
         summarize();
      end
   endtask

   // random upper bits, ignored
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] resp);
      int n;
      @(posedge clock);
      bq.push_back(resp);
      s_axi_awaddr <= a;
      s_axi_wdata <= (xs() & 32'hFFFFFF00) | {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      for (n = 0; n < 99 && s_axi_awready !== 1'b1; n++)
         @(posedge clock);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      guard(n);
      for (n = 0; n < 99 && s_axi_bvalid !== 1'b1; n++)
         @(posedge clock);
      guard(n);
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] want);
      int n;
      @(posedge clock);
      rq.push_back(want);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      for (n = 0; n < 99 && s_axi_arready !== 1'b1; n++)
         @(posedge clock);
      s_axi_arvalid <= 1'b0;
      guard(n);
      for (n = 0; n < 99 && s_axi_rvalid !== 1'b1; n++)
         @(posedge clock);
      guard(n);
   endtask

   task automatic tick(input int n);
      @(posedge clock);
      timer_tick <= 1'b1;
      repeat (n) @(posedge clock);
      timer_tick <= 1'b0;
   endtask

   // outputs settled by now
   task automatic see(input logic [8:0] v);
      #1;
      pq.push_back(v);
      -> look;
   endtask

   always @(posedge clock)
   begin
      if (s_axi_bvalid === 1'b1)
      begin
         bw = bq.pop_front();
         `CHK(s_axi_bresp, bw)
      end
      if (s_axi_rvalid === 1'b1)
      begin
         ew = rq.pop_front();
         `CHK({s_axi_rresp, s_axi_rdata}, ew)
      end
   end

   always @(look)
   begin
      pw = pq.pop_front();
      `CHK({pad_a, pad_b, pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, overflow_flag,
         compare_flag_a, compare_flag_b}, pw)
   end

   // ************************************************************
   // scenarios
   // ************************************************************
   initial
   begin
      repeat (6) @(posedge clock);
      rst_b <= 1'b1;
      see(9'h180);
      for (int a = 0; a < 36; a += 4)
         rd(8'(a), {(a == 32) ? timer8_pkg::resp_slverr : okay, 32'h0});
      wr(8'h20, 8'h00, timer8_pkg::resp_slverr);
      $display("reset test done");
      r = 8'(xs());
      wr(timer8_pkg::count_off, r, okay);
      rd(timer8_pkg::count_off, okv(r));
      wr(timer8_pkg::count_off, 8'hFE, okay);
      tick(2);
      see(9'h184);
      rd(timer8_pkg::count_off, okv(8'h00));
      wr(timer8_pkg::flags_off, 8'h01, okay);
      see(9'h180);
      wr(timer8_pkg::compare_b_off, 8'h10, okay);
      wr(timer8_pkg::count_off, 8'h10, okay);
      tick(1);
      see(9'h180);
      wr(timer8_pkg::count_off, 8'h0F, okay);
      tick(2);
      see(9'h181);
      wr(timer8_pkg::flags_off, 8'h07, okay);
      $display("normal mode test done");
      wr(timer8_pkg::compare_a_off, 8'h03, okay);
      wr(timer8_pkg::port_off, 8'h02, okay);
      wr(timer8_pkg::control_off, 8'h42, okay);
      wr(timer8_pkg::count_off, 8'h00, okay);
      tick(4);
      see(9'h1E2);
      rd(timer8_pkg::count_off, okv(8'h00));
      tick(4);
      see(9'h0A2);
      wr(timer8_pkg::flags_off, 8'h07, okay);
      wr(timer8_pkg::port_off, 8'h03, okay);
      st = 1'b0;
      for (int i = 0; i < 5; i++)
      begin
         wr(timer8_pkg::control_off, {sels[i], 6'h02}, okay);
         wr(timer8_pkg::force_off, 8'h01, okay);
         st = (sels[i] == 2'h3) | (sels[i] == 2'h1 && !st) | (sels[i] == 2'h0 && st);
         pa = (sels[i] != 2'h0) ? st : 1'b1;
         rd(timer8_pkg::status_off, okv({7'h0, st}));
         see({pa, 1'b1, pa, 1'b1, 5'h0});
      end
      rd(timer8_pkg::count_off, okv(8'h00));
      $display("clear on match test done");
      wr(timer8_pkg::control_off, 8'h00, okay);
      wr(timer8_pkg::compare_b_off, 8'h02, okay);
      wr(timer8_pkg::port_off, 8'h08, okay);
      wr(timer8_pkg::control_off, 8'h23, okay);
      wr(timer8_pkg::count_off, 8'hFE, okay);
      tick(2);
      see(9'h19C);
      tick(2);
      see(9'h19C);
      tick(1);
      see(9'h10D);
      rd(timer8_pkg::count_off, okv(8'h03));
      wr(timer8_pkg::control_off, 8'h47, okay);
      tick(1);
      see(9'h14F);
      $display("fast pwm test done");
      summarize();
   end
endmodule

`default_nettype wire
